/* design/sr_gate_seq.sv */
// Gate sequencer for a secondary synchronous rectifier.
// Assumes comparator, temperature and supply flags arrive asynchronously from analog logic.
module sr_gate_seq
    import sr_gate_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic above_upper_i,
    input wire logic below_lower_i,
    input wire logic off_cross_i,
    input wire logic above_reg_i,
    input wire logic vdd_on_i,
    input wire logic vin_high_i,
    input wire logic vin_low_i,
    input wire logic temp_hot_i,
    input wire logic temp_cool_i,
    input wire logic [CW-1:0] ref_cycles_i,
    output logic gate_on_o,
    output logic gate_sink_o,
    output logic drive_reduce_o,
    output logic vin_channel_o,
    output logic vdd_high_reg_o,
    output logic power_save_o,
    output logic thermal_off_o
);
    typedef struct packed {
        logic [8:0] s1;
        logic [8:0] s2;
        seq_e st;
        logic [CW-1:0] cnt;
        logic [CW-1:0] high_cnt;
        logic [15:0] ps_cnt;
        logic gate;
        logic sink;
        logic reduce;
        logic vin_ch;
        logic psave;
        logic otp;
    } state_s;
    state_s r, next_r;
    logic up, lo, offx, areg, von, vhi, vlo, hot, cool;

    // Named views of the second synchroniser stage.
    assign {up, lo, offx, areg, von, vhi, vlo, hot, cool} = r.s2;

    // The whole sequencer is one combinational update of the state copy.
    always_comb
    begin
        next_r = r;
        next_r.s1 = {above_upper_i, below_lower_i, off_cross_i, above_reg_i, vdd_on_i,
                     vin_high_i, vin_low_i, temp_hot_i, temp_cool_i};
        next_r.s2 = r.s1;
        next_r.reduce = 1'b0;
        // Supply channel choice; the divided slope copy and its thresholds are analog.
        if (!von)
        begin
            next_r.vin_ch = 1'b0;
        end
        else if (vhi)
        begin
            next_r.vin_ch = 1'b1;
        end
        else if (vlo)
        begin
            next_r.vin_ch = 1'b0;
        end
        // Power save timer runs while off and waiting for a turn-on.
        if (!r.gate && r.ps_cnt != 16'(PSAVE_CYC))
        begin
            next_r.ps_cnt = r.ps_cnt + 16'h0001;
        end
        if (!r.gate && r.ps_cnt == 16'(PSAVE_CYC - 1))
        begin
            next_r.psave = 1'b1;
        end
        case (r.st)
            ST_IDLE:
            begin
                // Count how long the slope copy stays above the upper threshold.
                if (up)
                begin
                    if (r.high_cnt != CW'(HL_BLANK_CYC))
                    begin
                        next_r.high_cnt = r.high_cnt + 10'h001;
                    end
                end
                else if (r.high_cnt == CW'(HL_BLANK_CYC))
                begin
                    next_r.st = ST_FALL;
                    next_r.cnt = CNT_ZERO;
                    next_r.high_cnt = CNT_ZERO;
                end
                else
                begin
                    next_r.high_cnt = CNT_ZERO;
                end
            end
            ST_FALL:
            begin
                // A slow fall is resonance, not a primary turn-off.
                if (lo)
                begin
                    next_r.st = (r.cnt < ref_cycles_i) ? ST_ON_DLY : ST_IDLE;
                    next_r.cnt = CNT_ZERO;
                end
                else if (r.cnt >= ref_cycles_i || up)
                begin
                    next_r.st = ST_IDLE;
                end
                else
                begin
                    next_r.cnt = r.cnt + 10'h001;
                end
            end
            ST_ON_DLY:
            begin
                if (r.cnt + 10'h001 >= CW'(ON_DELAY_CYC))
                begin
                    next_r.st = ST_MIN_ON;
                    next_r.gate = 1'b1;
                    next_r.sink = 1'b0;
                    next_r.psave = 1'b0;
                    next_r.cnt = CNT_ZERO;
                end
                else
                begin
                    next_r.cnt = r.cnt + 10'h001;
                end
            end
            ST_MIN_ON:
            begin
                // Ringing right after turn-on crosses the off threshold; ignore it.
                next_r.cnt = r.cnt + 10'h001;
                if (r.cnt + 10'h001 >= CW'(MIN_ON_CYC))
                begin
                    next_r.st = ST_COND;
                end
            end
            ST_COND:
            begin
                next_r.reduce = areg;
                if (offx)
                begin
                    next_r.st = ST_OFF_DLY;
                    next_r.cnt = CNT_ZERO;
                end
            end
            ST_OFF_DLY:
            begin
                // One cycle is the shortest honest delay at this clock rate.
                if (r.cnt + 10'h001 >= CW'(OFF_DELAY_CYC))
                begin
                    next_r.st = ST_MIN_OFF;
                    next_r.gate = 1'b0;
                    next_r.sink = 1'b1;
                    next_r.cnt = CNT_ZERO;
                    next_r.ps_cnt = 16'h0000;
                end
                else
                begin
                    next_r.cnt = r.cnt + 10'h001;
                end
            end
            ST_MIN_OFF:
            begin
                next_r.cnt = r.cnt + 10'h001;
                next_r.high_cnt = CNT_ZERO;
                if (r.cnt + 10'h001 >= CW'(MIN_OFF_CYC))
                begin
                    next_r.st = ST_IDLE;
                end
            end
            default:
            begin
                next_r.st = ST_IDLE;
            end
        endcase
        // Thermal shutdown overrides the sequencer state and forces the gate low.
        if (hot)
        begin
            next_r.otp = 1'b1;
        end
        else if (cool)
        begin
            next_r.otp = 1'b0;
        end
        if (next_r.otp)
        begin
            next_r.st = ST_IDLE;
            next_r.gate = 1'b0;
            next_r.sink = 1'b1;
            next_r.reduce = 1'b0;
            next_r.high_cnt = CNT_ZERO;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            r <= '{s1: 9'h000, s2: 9'h000, st: ST_IDLE, cnt: CNT_ZERO, high_cnt: CNT_ZERO,
                   ps_cnt: 16'h0000, gate: 1'b0, sink: 1'b1, reduce: 1'b0, vin_ch: 1'b0,
                   psave: 1'b0, otp: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign gate_on_o = r.gate;
    assign gate_sink_o = r.sink;
    assign drive_reduce_o = r.reduce;
    assign vin_channel_o = r.vin_ch;
    assign vdd_high_reg_o = r.vin_ch; // Low level regulation whenever drain channel.
    assign power_save_o = r.psave;
    assign thermal_off_o = r.otp;

    sequence turn_on_s;
        !r.gate ##1 r.gate;
    endsequence

    // Thermal shutdown may cut a minimum-on interval short; that is the only legal early drop.
    min_on_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        turn_on_s |-> (r.gate || r.otp) [*8]) else $error("gate dropped inside min on");
    otp_gate_low_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        r.otp |-> !r.gate) else $error("gate on during thermal off");
    off_delay_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (r.st == ST_COND && offx) |=> ##1 !r.gate && r.sink) else $error("turn off late");
    psave_exit_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        turn_on_s |-> !r.psave) else $error("power save kept on turn on");
    otp_resume_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (r.otp && !hot && !cool) |=> r.otp) else $error("early thermal resume");
    reduce_cond_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        r.reduce |-> r.gate) else $error("reduce while off");
    min_off_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (r.gate ##1 !r.gate) |-> !r.gate [*8]) else $error("retrigger in min off");
    vin_low_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (!von) |=> !r.vin_ch) else $error("vin channel before vdd on");
endmodule // sr_gate_seq

/* design/sr_gate_pkg.sv */
// Constants and types shared by the rectifier gate sequencer.
// Assumes a single 20 MHz clock; analog comparators are reduced to logic levels outside.
// What this block does
// - Slope sense voltage is drain sense divided by fifty; comparators use that copy.
// - Measure fall time from upper to zero threshold; compare with reference time.
// - Upper slope threshold is a fixed fraction of the sensed high level.
// - Turn on after delay only if high lasted blanking time and fall was fast.
// - After minimum on, while conducting, lower gate drive when drain is above regulation level.
// - On rising turn-off crossing, wait turn-off delay, then pull gate hard low.
// - The turn-off delay is kept minimal to limit primary overlap.
// - After turn-on, hold gate latched and ignore turn-off crossings for minimum on.
// - After turn-off, ignore drain ringing for the minimum off time.
// - Start on drain channel; after on threshold switch to supply input when high.
// - When supply input falls low, return to drain channel, low regulation level.
// - Start a timer at turn-off; reaching power save interval enters power save.
// - Leave power save on the next turn-on.
// - Above shutdown temperature, stop driving and hold the gate at zero.
// - Resume only once temperature falls below the recovery level.
package sr_gate_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned HL_BLANK_NS = 300;
    localparam int unsigned ON_DELAY_NS = 30;
    localparam int unsigned OFF_DELAY_NS = 10;
    localparam int unsigned MIN_ON_NS = 750;
    localparam int unsigned MIN_OFF_NS = 450;
    localparam int unsigned PSAVE_US = 20;
    // Least times round up, never below one cycle.
    function automatic int unsigned ns_up(input int unsigned ns);
        int unsigned c;
        c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int unsigned HL_BLANK_CYC = ns_up(HL_BLANK_NS);
    localparam int unsigned ON_DELAY_CYC = ns_up(ON_DELAY_NS);
    localparam int unsigned OFF_DELAY_CYC = ns_up(OFF_DELAY_NS);
    localparam int unsigned MIN_ON_CYC = ns_up(MIN_ON_NS);
    localparam int unsigned MIN_OFF_CYC = ns_up(MIN_OFF_NS);
    localparam int unsigned PSAVE_CYC = ns_up(PSAVE_US * 1000);
    localparam int CW = 10;
    localparam logic [CW-1:0] CNT_ZERO = 10'h000;
    typedef enum logic [2:0] {ST_IDLE, ST_FALL, ST_ON_DLY, ST_MIN_ON, ST_COND,
                              ST_OFF_DLY, ST_MIN_OFF} seq_e;
endpackage

/* dv/sense_front_model.sv */
// Behavioural drain-sense front end: comparators watching the scaled slope copy.
// Assumes one start pulse per switching event from the bench, on mclk_i.
module sense_front_model (
    input wire logic mclk_i,
    input wire logic start_i,
    input wire logic [7:0] high_len_i,
    input wire logic [7:0] fall_len_i,
    input wire logic drain_up_i,
    output logic above_upper_o,
    output logic below_lower_o,
    output logic off_cross_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase = 2'h0;
    logic [7:0] cnt = 8'h00;
    // Plateau, then fall, then held below zero until the drain rises again.
    always @(posedge mclk_i)
    begin
        if (start_i)
        begin
            phase <= 2'h1;
            cnt <= high_len_i;
        end
        else if (phase != 2'h0 && phase != 2'h3 && cnt <= 8'h01)
        begin
            phase <= phase + 2'h1;
            cnt <= fall_len_i;
        end
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end
    // The upper threshold follows the plateau, so the copy sits above it all along.
    assign above_upper_o = (phase == 2'h1);
    assign below_lower_o = (phase == 2'h3) && !drain_up_i;
    assign off_cross_o = drain_up_i;
endmodule // sense_front_model

/* dv/sync_rectifier_gate_sequencer_tb.sv */
// Self-checking bench for the rectifier gate sequencer.
// Assumes the sense front end model drives the comparator inputs.
module sync_rectifier_gate_sequencer_tb
    import sr_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, resetn_i = 1'b0, start = 1'b0, drain_up = 1'b1, above_reg = 1'b0;
    logic vdd_on = 1'b0, vin_high = 1'b1, vin_low = 1'b0, temp_hot = 1'b0, temp_cool = 1'b0;
    logic [CW-1:0] ref_cycles = 10'h014;
    logic [7:0] high_len = 8'h0a;
    logic up, lo, oc, gate, sink, reduce, chan, vreg, psave, toff, s;
    int n_mismatch = 0, samples_checked = 0;
    // Clock of 50 ns period.
    always #25 mclk_i = ~mclk_i;
    sense_front_model i_sense_front_model (.mclk_i(mclk_i), .start_i(start),
        .high_len_i(high_len), .fall_len_i(8'h03), .drain_up_i(drain_up),
        .above_upper_o(up), .below_lower_o(lo), .off_cross_o(oc));
    sr_gate_seq i_sr_gate_seq (.mclk_i(mclk_i), .resetn_i(resetn_i), .above_upper_i(up),
        .below_lower_i(lo), .off_cross_i(oc), .above_reg_i(above_reg), .vdd_on_i(vdd_on),
        .vin_high_i(vin_high), .vin_low_i(vin_low), .temp_hot_i(temp_hot),
        .temp_cool_i(temp_cool), .ref_cycles_i(ref_cycles), .gate_on_o(gate),
        .gate_sink_o(sink), .drive_reduce_o(reduce), .vin_channel_o(chan),
        .vdd_high_reg_o(vreg), .power_save_o(psave), .thermal_off_o(toff));
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // Bounded wait; a hang here shows up as a failed compare, not a stall.
    // Returns at the first negedge that shows the wanted level, so callers keep exact timing.
    task automatic await_gate(input logic v, input int n, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++)
        begin
            @(negedge mclk_i);
            seen = (gate === v);
        end
    endtask
    // Let any minimum-off blanking run out first, so each event starts from idle.
    task automatic fire(output logic seen);
        tick(int'(MIN_OFF_CYC) + 4);
        @(posedge mclk_i) start <= 1'b1;
        drain_up <= 1'b0;
        @(posedge mclk_i) start <= 1'b0;
        await_gate(1'b1, 40, seen);
    endtask
    // Off crossing arrives inside min-on and must wait out the blanking.
    task automatic t_on_min_on;
        fire(s);
        check_bit(s, 1'b1);
        @(posedge mclk_i) drain_up <= 1'b1;
        tick(10);
        check_bit(gate, 1'b1);
        await_gate(1'b0, 30, s);
        check_bit(s, 1'b1);
        check_bit(sink, 1'b1);
        $display("test on_min_on done");
    endtask
    task automatic t_conduct;
        fire(s);
        tick(25);
        @(posedge mclk_i) above_reg <= 1'b1;
        tick(5);
        check_bit(reduce, 1'b1);
        @(posedge mclk_i) drain_up <= 1'b1;
        above_reg <= 1'b0;
        await_gate(1'b0, 6, s);
        check_bit(s, 1'b1);
        $display("test conduct done");
    endtask
    // Slow fall against a short reference, then a plateau too short to qualify.
    task automatic t_refuse;
        @(posedge mclk_i) ref_cycles <= 10'h002;
        fire(s);
        check_bit(s, 1'b0);
        @(posedge mclk_i) ref_cycles <= 10'h014;
        drain_up <= 1'b1;
        tick(20);
        force_short();
        $display("test refuse done");
    endtask
    // A fast fall after a plateau shorter than the high-level blanking must not qualify.
    task automatic force_short;
        @(posedge mclk_i) start <= 1'b1;
        drain_up <= 1'b0;
        high_len <= 8'h03;
        @(posedge mclk_i) start <= 1'b0;
        await_gate(1'b1, 30, s);
        check_bit(s, 1'b0);
        @(posedge mclk_i) drain_up <= 1'b1;
        high_len <= 8'h0a;
    endtask
    // Power save entry is timed from a turn-off, two cycles either side of the interval.
    task automatic t_psave;
        fire(s);
        @(posedge mclk_i) drain_up <= 1'b1;
        await_gate(1'b0, 30, s);
        tick(int'(PSAVE_CYC) - 2);
        check_bit(psave, 1'b0);
        tick(4);
        check_bit(psave, 1'b1);
        fire(s);
        tick(3);
        check_bit(psave, 1'b0);
        @(posedge mclk_i) drain_up <= 1'b1;
        await_gate(1'b0, 30, s);
        $display("test psave done");
    endtask
    task automatic t_thermal;
        @(posedge mclk_i) temp_hot <= 1'b1;
        tick(5);
        check_bit(toff, 1'b1);
        fire(s);
        check_bit(s, 1'b0);
        @(posedge mclk_i) temp_hot <= 1'b0;
        drain_up <= 1'b1;
        tick(5);
        check_bit(toff, 1'b1);
        @(posedge mclk_i) temp_cool <= 1'b1;
        tick(5);
        check_bit(toff, 1'b0);
        @(posedge mclk_i) temp_cool <= 1'b0;
        $display("test thermal done");
    endtask
    task automatic t_supply;
        check_bit(chan, 1'b0);
        @(posedge mclk_i) vdd_on <= 1'b1;
        tick(5);
        check_bit(chan, 1'b1);
        @(posedge mclk_i) vin_high <= 1'b0;
        vin_low <= 1'b1;
        tick(5);
        check_bit(vreg, 1'b0);
        $display("test supply done");
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence; the watchdog below covers a hang anywhere in it.
    initial
    begin
        tick(20);
        check_bit(sink, 1'b1);
        @(posedge mclk_i) resetn_i <= 1'b1;
        tick(5);
        t_supply();
        t_on_min_on();
        t_conduct();
        t_refuse();
        t_psave();
        t_thermal();
        print_verdict();
    end
    initial
    begin
        #250us;
        n_mismatch++;
        print_verdict();
    end
endmodule // sync_rectifier_gate_sequencer_tb
